//--- cms_cfg_host.sv
// far-side configuration system: pulse sender, reply receiver
module cms_cfg_host (
    input wire logic clock,
    input wire logic tx_current,
    output logic bus_positive_pin,
    output logic bus_negative_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        bus_positive_pin = 1'b0;
        bus_negative_pin = 1'b0;
    end
    // high time carries each bit, lsb first
    task automatic send(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++)
        begin
            bus_positive_pin <= 1'b1;
            repeat (v[i] ? 130 : 40) @(posedge clock);
            bus_positive_pin <= 1'b0;
            repeat (20) @(posedge clock);
        end
    endtask
    // samples the first half of each manchester bit
    task automatic recv(output logic [17:0] r);
        int t;
        t = 0;
        r = 18'h0;
        while (tx_current !== 1'b1 && t < 3000)
        begin
            @(posedge clock);
            t++;
        end
        if (t < 3000)
        begin
            repeat (80) @(posedge clock);
            for (int i = 0; i < 18; i++)
            begin
                r[i] = tx_current;
                repeat (320) @(posedge clock);
            end
        end
    endtask
endmodule

//--- cms_config_serial.sv
// configuration-mode serial protocol: key detect, command decode, reply
`include "cms_regs.svh"
module cms_config_serial
    import cms_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bus_positive_pin,
    input wire logic bus_negative_pin,
    input wire logic async_mode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_current,
    output logic sync_pulse,
    output logic analog_chain_out_enable
);
    localparam int INIT_CYC = `CMS_INIT_CYC;
    localparam int GAP_CYC = `CMS_GAP_CYC;
    localparam int THR_CYC = `CMS_BIT_THR_CYC;
    localparam int HALF_CYC = `CMS_HALF_CYC;

    // pin synchronisers
    logic [1:0] vp_sync_ff;
    logic [1:0] vn_sync_ff;
    logic line_ff;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vp_sync_ff <= 2'h0;
            vn_sync_ff <= 2'h0;
            line_ff <= 1'b0;
        end
        else
        begin
            vp_sync_ff <= {vp_sync_ff[0], bus_positive_pin};
            vn_sync_ff <= {vn_sync_ff[0], bus_negative_pin};
            line_ff <= vp_sync_ff[1] & ~vn_sync_ff[1];
        end
    end
    // modulation is the positive pin taken relative to the negative pin
    wire line_hi = vp_sync_ff[1] & ~vn_sync_ff[1]; // RL5
    wire rise = line_hi & ~line_ff;
    wire fall = ~line_hi & line_ff;

    // pulse duration measurement and bit shift
    logic [15:0] wid_ff;
    logic [15:0] gap_ff;
    logic [15:0] shreg_ff;
    logic [4:0] nbits_ff;
    logic frame_done;
    wire bit_val = (wid_ff >= 16'(THR_CYC)); // RL24
    wire gap_end = (gap_ff == 16'(GAP_CYC)) && (nbits_ff != 5'd0);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wid_ff <= 16'h0;
            gap_ff <= 16'h0;
            shreg_ff <= 16'h0;
            nbits_ff <= 5'h0;
        end
        else
        begin
            wid_ff <= rise ? 16'h0 : (line_hi ? wid_ff + 16'h1 : wid_ff);
            if (line_hi || rise)
                gap_ff <= 16'h0;
            else if (gap_ff != 16'hffff)
                gap_ff <= gap_ff + 16'h1;
            if (gap_end)
                nbits_ff <= 5'h0;
            else if (fall && nbits_ff != 5'd31)
            begin
                // lsb first: shift in from the top
                shreg_ff <= {bit_val, shreg_ff[15:1]}; // RL2 RL19 RL24
                nbits_ff <= nbits_ff + 5'h1;
            end
        end
    end
    assign frame_done = gap_end;
    // a 14-bit frame sits in bits 15:2 after shifting
    wire [13:0] cmd = shreg_ff[15:2];
    wire is_key = (nbits_ff == `CMS_KEY_BITS) && (shreg_ff == `CMS_KEY); // RL1 RL4
    wire is_cmd = (nbits_ff == `CMS_CMD_BITS); // RL4
    wire [7:0] cmd_data = cmd[7:0]; // RL16 RL25
    wire [3:0] cmd_addr = cmd[11:8]; // RL25
    wire cmd_rd = cmd[12]; // RL17
    wire cmd_par_ok = ~^cmd; // RL18 RL25

    // mode and init phase timer
    cms_mode_t mode_ff;
    logic [15:0] init_cnt_ff;
    logic [7:0] regs_ff [0:15];
    logic tx_busy;
    logic tx_go;
    logic [3:0] tx_addr;
    logic [7:0] tx_data;
    logic [2:0] tx_sv;
    wire init_over = (init_cnt_ff == 16'(INIT_CYC));
    wire locked = regs_ff[`CMS_REG2_ADDR][`CMS_LOCK_BIT];
    wire do_cmd = (mode_ff == CMS_CONFIG) && frame_done && is_cmd && !tx_busy;
    wire wr_ok = do_cmd && cmd_par_ok && !cmd_rd && !locked; // RL17
    wire exit_cmd = do_cmd && cmd_par_ok && !cmd_rd && cmd_addr == `CMS_EXIT_ADDR
        && cmd_data == `CMS_EXIT_DATA;
    // entry only while still in the init phase
    wire enter = (mode_ff == CMS_INIT) && frame_done && is_key && !init_over; // RL3
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_ff <= CMS_INIT;
            init_cnt_ff <= 16'h0;
        end
        else
        begin
            if (mode_ff == CMS_INIT && !init_over)
                init_cnt_ff <= init_cnt_ff + 16'h1;
            if (enter)
                mode_ff <= CMS_CONFIG; // RL1
            else if (mode_ff == CMS_INIT && init_over)
                mode_ff <= CMS_NORMAL; // RL7
            else if (exit_cmd)
            begin
                mode_ff <= CMS_INIT; // RL23
                init_cnt_ff <= 16'h0;
            end
        end
    end
    // after init, pulses are sync pulses only in synchronous mode
    assign sync_pulse = (mode_ff == CMS_NORMAL) && rise && !async_mode; // RL7

    // apb slave for the configuration ram
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire reg_hit = paddr[11:6] == 6'h0 && paddr[5:4] != 2'h0
        && paddr[1:0] == 2'h0;
    wire [3:0] reg_idx = paddr[5:2] - 4'h4;
    wire apb_reg_wr = apb_wr && reg_hit;
    assign pready = 1'b1;
    assign pslverr = apb_acc && !(reg_hit || paddr == `CMS_A_STAT
        || paddr == `CMS_A_CTRL);
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                regs_ff[i] <= 8'h0;
        end
        else if (wr_ok && cmd_addr != `CMS_EXIT_ADDR)
            regs_ff[cmd_addr] <= cmd_data;
        else if (apb_reg_wr)
            regs_ff[reg_idx] <= pwdata[7:0];
    end
    // default 0 keeps the analog chain output off
    assign analog_chain_out_enable = regs_ff[0][`CMS_OE_BIT]; // RL20
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
        begin
            if (reg_hit)
                prdata <= {24'h0, regs_ff[reg_idx]};
            else if (paddr == `CMS_A_STAT)
                prdata <= {29'h0, tx_busy, 2'(mode_ff)};
            else
                prdata <= 32'h0;
        end
    end

    // reply selection
    always_comb
    begin
        tx_go = 1'b0;
        tx_addr = 4'h0;
        tx_data = 8'h0;
        tx_sv = `CMS_SV_OK; // RL13
        if (enter)
        begin
            tx_go = 1'b1; // RL6
            tx_addr = `CMS_REG2_ADDR;
            tx_data = regs_ff[`CMS_REG2_ADDR];
        end
        else if (do_cmd && !cmd_par_ok)
        begin
            tx_go = 1'b1; // RL21
            tx_sv = `CMS_SV_ERR;
        end
        else if (do_cmd)
        begin
            tx_go = 1'b1; // RL22
            tx_addr = cmd_addr;
            tx_data = wr_ok ? cmd_data : regs_ff[cmd_addr];
        end
    end
    // fixed format: no options from stored configuration apply here
    wire [14:0] word_lo = {tx_addr, tx_data, tx_sv}; // RL8 RL12
    wire [15:0] word = {^word_lo, word_lo}; // RL14 RL15
    // start bits 1 then 0 go first, then word lsb first
    wire [17:0] frame = {word, 2'b01}; // RL10 RL11

    // manchester transmitter
    logic [17:0] txsh_ff;
    logic [4:0] txcnt_ff;
    logic [15:0] half_ff;
    logic phase_ff;
    assign tx_busy = (txcnt_ff != 5'h0);
    wire half_tick = (half_ff == 16'(HALF_CYC - 1));
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txsh_ff <= 18'h0;
            txcnt_ff <= 5'h0;
            half_ff <= 16'h0;
            phase_ff <= 1'b0;
        end
        else if (tx_go && !tx_busy)
        begin
            txsh_ff <= frame;
            txcnt_ff <= `CMS_FRAME_BITS;
            half_ff <= 16'h0;
            phase_ff <= 1'b0;
        end
        else if (tx_busy)
        begin
            half_ff <= half_tick ? 16'h0 : half_ff + 16'h1;
            if (half_tick)
            begin
                phase_ff <= ~phase_ff;
                if (phase_ff)
                begin
                    txsh_ff <= {1'b0, txsh_ff[17:1]};
                    txcnt_ff <= txcnt_ff - 5'h1;
                end
            end
        end
    end
    // manchester-1: a 1 is high then low, a 0 low then high
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tx_current <= 1'b0;
        else
            tx_current <= tx_busy && (txsh_ff[0] ^ phase_ff); // RL9
    end

    frame_len_a: assert property ( // RL11
        @(posedge clock) disable iff (!rst_n)
        tx_go && !tx_busy |=> tx_busy [*8])
        else $error("frame too short");
    enter_ack_a: assert property ( // RL6
        @(posedge clock) disable iff (!rst_n)
        enter |=> mode_ff == CMS_CONFIG && txsh_ff[1:0] == 2'b01)
        else $error("entry not acknowledged");
    par_even_a: assert property ( // RL14
        @(posedge clock) disable iff (!rst_n)
        tx_go && !tx_busy |=> ~^txsh_ff[17:2])
        else $error("odd parity out");
    err_sv_a: assert property ( // RL21
        @(posedge clock) disable iff (!rst_n)
        do_cmd && !cmd_par_ok |=> txsh_ff[17:2] == 16'h0006)
        else $error("bad error frame");
    late_key_a: assert property ( // RL3
        @(posedge clock) disable iff (!rst_n)
        init_over && mode_ff != CMS_CONFIG |=> mode_ff != CMS_CONFIG)
        else $error("key taken late");
    exit_a: assert property ( // RL23
        @(posedge clock) disable iff (!rst_n)
        exit_cmd |=> mode_ff == CMS_INIT && init_cnt_ff == 16'h0)
        else $error("exit failed");
    wr_a: assert property ( // RL17
        @(posedge clock) disable iff (!rst_n)
        wr_ok && cmd_addr != `CMS_EXIT_ADDR |=>
        regs_ff[$past(cmd_addr)] == $past(cmd_data))
        else $error("write lost");
    sync_a: assert property ( // RL7
        @(posedge clock) disable iff (!rst_n)
        sync_pulse |-> mode_ff == CMS_NORMAL && !async_mode)
        else $error("sync pulse out of place");
    idle_low_a: assert property ( // RL9
        @(posedge clock) disable iff (!rst_n)
        !tx_busy |=> !tx_current)
        else $error("line not idle");
    half_len_a: assert property ( // RL9
        @(posedge clock) disable iff (!rst_n)
        half_tick |=> !half_tick [*8])
        else $error("half bit too short");
    start_bits_a: assert property ( // RL10
        @(posedge clock) disable iff (!rst_n)
        tx_go && !tx_busy |=> txsh_ff[1:0] == 2'b01)
        else $error("bad start bits");
    field_pos_a: assert property ( // RL12
        @(posedge clock) disable iff (!rst_n)
        tx_go && !tx_busy |=> txsh_ff[16:13] == $past(tx_addr)
        && txsh_ff[12:5] == $past(tx_data))
        else $error("field misplaced");
    sv_ok_a: assert property ( // RL13
        @(posedge clock) disable iff (!rst_n)
        tx_go && !tx_busy && !(do_cmd && !cmd_par_ok) |=>
        txsh_ff[4:2] == `CMS_SV_OK)
        else $error("bad state vector");
    keep_reg_a: assert property ( // RL25
        @(posedge clock) disable iff (!rst_n)
        do_cmd && (!cmd_par_ok || cmd_rd || locked) && !apb_reg_wr |=>
        regs_ff[$past(cmd_addr)] == $past(regs_ff[cmd_addr]))
        else $error("register changed");
    key_len_a: assert property ( // RL4
        @(posedge clock) disable iff (!rst_n)
        frame_done && nbits_ff == `CMS_CMD_BITS |-> !enter)
        else $error("short frame taken as key");
endmodule

//--- cms_config_serial_tb_top.sv
// testbench: key entry, commands, replies, apb access, exit
`include "cms_regs.svh"
module cms_config_serial_tb_top
    import cms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic async_mode = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, tx_current, sync_pulse, oe, pos, neg;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 70;
    int sync_n = 0;
    int s0;
    logic [7:0] mem [16];
    logic [31:0] rd;
    logic err;
    logic [3:0] a;
    logic [7:0] d;
    always #12.5 clock = ~clock;
    always @(posedge clock)
        if (sync_pulse === 1'b1)
            sync_n <= sync_n + 1;
    cms_config_serial dut_u (.clock(clock), .rst_n(rst_n),
        .bus_positive_pin(pos), .bus_negative_pin(neg),
        .async_mode(async_mode), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_current(tx_current), .sync_pulse(sync_pulse),
        .analog_chain_out_enable(oe));
    cms_cfg_host host_u (.clock(clock), .tx_current(tx_current),
        .bus_positive_pin(pos), .bus_negative_pin(neg));
    function automatic logic [17:0] frm(logic [3:0] fa, logic [7:0] fd,
        logic [2:0] s);
        return {^{fa, fd, s}, fa, fd, s, 2'b01};
    endfunction
    task automatic end_of_test();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t value %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_frm(input logic [17:0] exp);
        logic [17:0] r;
        host_u.recv(r);
        comparisons++;
        if (r !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t frame %h exp %h", $time, r, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic cmd(input logic rw, input logic [3:0] ad,
        input logic [7:0] dd, input logic bad);
        host_u.send({2'b00, ^{rw, ad, dd} ^ bad, rw, ad, dd}, 14);
    endtask
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        host_u.send(`CMS_KEY, 16);
        chk_frm(frm(`CMS_REG2_ADDR, mem[2], `CMS_SV_OK));
        apb(1'b0, `CMS_A_STAT, 32'h0);
        chk_val(rd & 32'h3, 32'(CMS_CONFIG));
        a = 4'h3 + 4'({$random(seed)} % 7);
        d = 8'($random(seed));
        cmd(1'b0, a, d, 1'b0);
        mem[a] = d;
        chk_frm(frm(a, d, `CMS_SV_OK));
        cmd(1'b1, a, ~d, 1'b0);
        chk_frm(frm(a, mem[a], `CMS_SV_OK));
        cmd(1'b0, a, ~d, 1'b1);
        chk_frm(frm(4'h0, 8'h00, `CMS_SV_ERR));
        apb(1'b0, `CMS_A_REG0 + 12'(4 * a), 32'h0);
        chk_val(rd & 32'hff, {24'h0, mem[a]});
        chk_val({31'h0, oe}, 32'h0);
        cmd(1'b0, 4'h0, 8'h01, 1'b0);
        chk_frm(frm(4'h0, 8'h01, `CMS_SV_OK));
        chk_val({31'h0, oe}, 32'h1);
        d = 8'($random(seed));
        apb(1'b1, `CMS_A_REG0 + 12'hc, {24'h0, d});
        mem[3] = d;
        cmd(1'b1, 4'h3, 8'h00, 1'b0);
        chk_frm(frm(4'h3, mem[3], `CMS_SV_OK));
        apb(1'b0, 12'h040, 32'h0);
        chk_val({31'h0, err}, 32'h1);
        cmd(1'b0, `CMS_EXIT_ADDR, `CMS_EXIT_DATA, 1'b0);
        fork
            chk_frm(frm(`CMS_EXIT_ADDR, `CMS_EXIT_DATA, `CMS_SV_OK));
            begin
                // mode read inside the restarted init phase
                repeat (3000) @(posedge clock);
                apb(1'b0, `CMS_A_STAT, 32'h0);
                chk_val(rd & 32'h3, 32'(CMS_INIT));
            end
        join
        chk_val({31'h0, oe}, 32'h1);
        repeat (`CMS_INIT_CYC + 100) @(posedge clock);
        s0 = sync_n;
        host_u.send(`CMS_KEY, 16);
        chk_val(32'(sync_n - s0), 32'h0);
        async_mode <= 1'b0;
        @(posedge clock);
        s0 = sync_n;
        host_u.send(`CMS_KEY, 16);
        chk_val(32'(sync_n - s0), 32'h10);
        apb(1'b0, `CMS_A_STAT, 32'h0);
        chk_val(rd & 32'h3, 32'(CMS_NORMAL));
        end_of_test();
    end
    initial
    begin
        repeat (90000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
endmodule

//--- cms_pkg.sv
// types for the configuration-mode serial protocol block
package cms_pkg;
    typedef enum logic [1:0] {CMS_INIT, CMS_CONFIG, CMS_NORMAL} cms_mode_t;
endpackage

//--- cms_regs.svh
// constants for the configuration-mode serial protocol block
// Overview of operation
// RL1: key 0x5A5A, 16 bits, no start or parity, enters configuration mode.
// RL2: the configuration system shifts the key out least significant bit first.
// RL3: key accepted only during the initialization phase after power-up.
// RL4: key frames are 16 bits, command frames 14 bits; length tells them apart.
// RL5: inbound traffic is pulse-duration modulated voltage on the bus pins.
// RL6: on entry the device answers with config register two contents.
// RL7: without key in time, later pulses become sync pulses or are ignored.
// RL8: outbound config frame format is fixed; sync response and auto-zero off.
// RL9: responses go out current-modulated, Manchester-1 encoded.
// RL10: every outbound frame starts with start bits 1 then 0.
// RL11: frame is 18 bits: two start bits plus 16-bit word, LSB first.
// RL12: word: parity bit 15, address 14:11, data 10:3, state vector 2:0.
// RL13: normal responses carry state vector 101b.
// RL14: parity makes the 16-bit word hold an even count of ones.
// RL15: parity, not CRC, marks configuration frames apart from normal ones.
// RL16: inbound frame holds 8 data bits, r/w bit, 4 address bits, parity.
// RL17: read/write bit 0 writes, 1 reads.
// RL18: inbound parity makes the count of ones in the frame even.
// RL19: inbound command frames are sent least significant bit first.
// RL20: analog chain output enabled only when its enable bit is 1; default 0.
// RL21: inbound parity error answers state vector 110b with zero data and address.
// RL22: each completed read or write is acknowledged by one handshake frame.
// RL23: write 0x80 to address 1010b: handshake, exit, restart init phase.
// RL24: bits recovered by pulse duration against the clock; bits counted.
// RL25: inbound order data, address, r/w, parity; parity checked first.
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH
`define CMS_KEY 16'h5a5a
`define CMS_KEY_BITS 5'd16
`define CMS_CMD_BITS 5'd14
`define CMS_SV_OK 3'h5
`define CMS_SV_ERR 3'h6
`define CMS_EXIT_ADDR 4'ha
`define CMS_EXIT_DATA 8'h80
`define CMS_REG2_ADDR 4'h2
`define CMS_CLK_NS 25
// pulse width threshold between a 0 and a 1 (high time), in ns
`define CMS_BIT_THR_NS 3000
`define CMS_BIT_THR_CYC (`CMS_BIT_THR_NS / `CMS_CLK_NS)
// bus idle time that ends a frame, in ns
`define CMS_GAP_NS 40000
`define CMS_GAP_CYC (`CMS_GAP_NS / `CMS_CLK_NS)
// initialization phase length, in ns
`define CMS_INIT_NS 100000
`define CMS_INIT_CYC (`CMS_INIT_NS / `CMS_CLK_NS)
// manchester half-bit time, in ns
`define CMS_HALF_NS 4000
`define CMS_HALF_CYC (`CMS_HALF_NS / `CMS_CLK_NS)
`define CMS_FRAME_BITS 5'd18
`define CMS_OE_BIT 0
`define CMS_LOCK_BIT 7
// apb register offsets
`define CMS_A_CTRL 12'h000
`define CMS_A_STAT 12'h004
`define CMS_A_REG0 12'h010
`define CMS_REG_FILE_BITS 4
`endif
